//--- mdp_pkg.sv
// shared constants for the machine-cycle sequencer and its strobe timer
// assumes one core clock; the register port of the core reaches these addresses
package mdp_pkg;
	// register addresses on the core's special-function port
	localparam logic [7:0] SEL_ADDR = 8'h86;
	localparam logic [7:0] CLKCTL_ADDR = 8'h8e;
	localparam logic [7:0] PTR_LOW_ADDR = 8'h82;
	localparam logic [7:0] PTR_HIGH_ADDR = 8'h83;
	// field layout and reset values
	localparam int SEL_BIT = 0;
	localparam int STRETCH_LSB = 0;
	localparam int STRETCH_W = 3;
	localparam logic [2:0] STRETCH_RST = 3'h1;
	localparam logic [7:0] SEL_RST = 8'h00;
	// timing counts
	localparam logic [2:0] MAX_INSTR_CYCLES = 3'h5;
	localparam logic [3:0] XMOVE_BASE_CYCLES = 4'h2;
	localparam logic [4:0] STROBE_MIN_CLOCKS = 5'h02;
	localparam int STROBE_W = 5;

	typedef enum logic [1:0] {FIRST_STATE, SECOND_STATE, THIRD_STATE, FOURTH_STATE} mdp_state_t;

	// strobe width in clocks: 2 for no stretch, else four per stretch step
	function automatic logic [STROBE_W-1:0] mdp_strobe_clocks(input logic [2:0] stretch);
		logic [STROBE_W-1:0] w;
		w = {stretch, 2'b00};
		if (stretch == 3'h0) begin
			w = STROBE_MIN_CLOCKS;
		end
		return w;
	endfunction
endpackage

//--- mdp_sequencer.sv
// machine-cycle sequencer with external data move timing and two data pointers
// assumes the core presents each instruction's descriptor during the last fourth state
// of the instruction before it, and that all inputs except the data pins are core-clocked
//
// Operation
// - every machine cycle is four clocks, first to fourth state in order
// - internal timing uses both rising and falling clock edges
// - one opcode fetch per machine cycle
// - single-cycle opcodes finish in one four-clock machine cycle
// - ordinary instructions last one to five machine cycles
// - external data move lasts two to nine machine cycles
// - read and write strobes widen with the added cycles
// - register-indirect move takes low address from working register
// - register-indirect move takes high address from port two latch
// - pointer-indirect move drives all sixteen bits from selected pointer
// - select bit is bit zero of register at 86h
// - upper seven select register bits always read zero
// - select zero uses primary pointer, one uses secondary
// - incrementing the select register flips the selection
// - stretch is a three-bit field in the clock control register
// - stretch resets to one, giving three-cycle moves
// - strobe lasts 2,4,8,...,28 clocks for stretch 0 to 7
module mdp_sequencer
	import mdp_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// next instruction descriptor
	input wire logic [2:0] INSTR_CYCLES_I,
	input wire logic INSTR_XMOVE_I,
	input wire logic XMOVE_WRITE_I,
	input wire logic XMOVE_VIA_POINTER_I,
	input wire logic [7:0] WORK_REG_I,
	input wire logic [7:0] PORT2_LATCH_I,
	input wire logic [7:0] XMOVE_WDATA_I,
	input wire logic POINTER_INC_I,
	// register port
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic [7:0] SFR_WDATA_I,
	output logic [7:0] SFR_RDATA_O,
	// timing outputs
	output logic [1:0] STATE_O,
	output logic [1:0] STATE_LATE_O,
	output logic FETCH_O,
	output logic INSTR_DONE_O,
	// external data pins
	output logic [15:0] XADDR_O,
	output logic [7:0] XDATA_O,
	output logic XDATA_OE_O,
	input wire logic [7:0] XDATA_I,
	output logic XREAD_N_O,
	output logic XWRITE_N_O,
	output logic [7:0] XMOVE_RDATA_O,
	output logic XMOVE_RVALID_O,
	output logic POINTER_SELECT_O
);
	mdp_strobe_if strb ();

	mdp_strobe_timer u_timer (
		.clk_i(CORE_CLK_I),
		.rst_n_i(RST_N_I),
		.strb(strb.timer)
	);

	mdp_state_t state_reg, state_next;
	logic [3:0] left_reg, left_next;
	logic [3:0] idx_reg, idx_next;
	logic xmove_reg, xmove_next;
	logic write_reg, write_next;
	logic [2:0] stretch_reg, stretch_next;
	logic [2:0] mv_stretch_reg, mv_stretch_next;
	logic sel_reg, sel_next;
	logic [15:0] ptr_reg [2];
	logic [15:0] ptr_next [2];
	logic [15:0] addr_reg, addr_next;
	logic [7:0] wdata_reg, wdata_next;
	logic oe_reg, oe_next;
	logic rd_n_reg, rd_n_next;
	logic wr_n_reg, wr_n_next;
	logic rd_d1_reg;
	logic [7:0] rdata_reg, rdata_next;
	logic rvalid_reg, rvalid_next;
	logic [7:0] sfr_rdata_reg, sfr_rdata_next;
	logic fetch_reg, done_reg, done_next;
	logic [1:0] late_reg;
	logic [7:0] xdata_s1_reg, xdata_s2_reg;
	logic instr_end;
	logic [2:0] cyc_clamped;

	// sequencing, pointers, registers and pins: next values
	always_comb begin
		state_next = state_reg;
		left_next = left_reg;
		idx_next = idx_reg;
		xmove_next = xmove_reg;
		write_next = write_reg;
		stretch_next = stretch_reg;
		mv_stretch_next = mv_stretch_reg;
		sel_next = sel_reg;
		ptr_next = ptr_reg;
		addr_next = addr_reg;
		wdata_next = wdata_reg;
		oe_next = oe_reg;
		done_next = 1'b0;
		rdata_next = rdata_reg;
		rvalid_next = 1'b0;
		strb.start = 1'b0;
		strb.width = mdp_strobe_clocks(mv_stretch_reg);
		cyc_clamped = INSTR_CYCLES_I;
		instr_end = (state_reg == FOURTH_STATE) && (left_reg == 4'h1);

		// four fixed states per machine cycle
		case (state_reg)
			FIRST_STATE: state_next = SECOND_STATE;
			SECOND_STATE: state_next = THIRD_STATE;
			THIRD_STATE: state_next = FOURTH_STATE;
			FOURTH_STATE: state_next = FIRST_STATE;
			default: state_next = FIRST_STATE;
		endcase

		// machine-cycle bookkeeping; a fetch starts each new machine cycle
		if (state_reg == FOURTH_STATE) begin
			left_next = left_reg - 4'h1;
			idx_next = idx_reg + 4'h1;
		end

		// zero cycles is taken as one, anything above five as five
		if (cyc_clamped == 3'h0) begin
			cyc_clamped = 3'h1;
		end else if (cyc_clamped > MAX_INSTR_CYCLES) begin
			cyc_clamped = MAX_INSTR_CYCLES;
		end

		// take the next instruction at the end of the current one
		if (instr_end) begin
			done_next = 1'b1;
			idx_next = 4'h1;
			xmove_next = INSTR_XMOVE_I;
			write_next = XMOVE_WRITE_I;
			oe_next = 1'b0;
			left_next = {1'b0, cyc_clamped};
			if (INSTR_XMOVE_I) begin
				// stretch frozen for the whole move so a mid-move write cannot skew it
				mv_stretch_next = stretch_reg;
				left_next = XMOVE_BASE_CYCLES + {1'b0, stretch_reg};
				wdata_next = XMOVE_WDATA_I;
				if (XMOVE_VIA_POINTER_I) begin
					addr_next = ptr_reg[sel_reg];
				end else begin
					addr_next = {PORT2_LATCH_I, WORK_REG_I};
				end
			end
		end

		// strobe begins in the second machine cycle, one clock later for stretched moves
		if (xmove_reg && (mv_stretch_reg == 3'h0) && (idx_reg == 4'h1) &&
			(state_reg == FOURTH_STATE) && !instr_end) begin
			strb.start = 1'b1;
		end
		if (xmove_reg && (mv_stretch_reg != 3'h0) && (idx_reg == 4'h2) &&
			(state_reg == FIRST_STATE)) begin
			strb.start = 1'b1;
		end
		// write data is driven from the second machine cycle to the end of the move
		if (xmove_reg && write_reg && (idx_reg == 4'h1) && (state_reg == FOURTH_STATE) &&
			!instr_end) begin
			oe_next = 1'b1;
		end

		rd_n_next = !(strb.active && !write_reg);
		wr_n_next = !(strb.active && write_reg);

		// read data taken from the synchronised pins as the read strobe ends
		if (rd_n_reg && !rd_d1_reg) begin
			rdata_next = xdata_s2_reg;
			rvalid_next = 1'b1;
		end

		// pointer increment acts on the selected pointer only
		if (POINTER_INC_I) begin
			ptr_next[sel_reg] = ptr_reg[sel_reg] + 16'h0001;
		end

		// register writes
		if (SFR_WR_I) begin
			case (SFR_ADDR_I)
				// only bit zero is kept, so writing back old+1 flips it
				SEL_ADDR: sel_next = SFR_WDATA_I[SEL_BIT];
				CLKCTL_ADDR: stretch_next = SFR_WDATA_I[STRETCH_LSB +: STRETCH_W];
				PTR_LOW_ADDR: ptr_next[sel_reg][7:0] = SFR_WDATA_I;
				PTR_HIGH_ADDR: ptr_next[sel_reg][15:8] = SFR_WDATA_I;
				default: ;
			endcase
		end

		// register reads, one clock behind the address
		case (SFR_ADDR_I)
			SEL_ADDR: sfr_rdata_next = {7'h00, sel_reg};
			CLKCTL_ADDR: sfr_rdata_next = {5'h00, stretch_reg};
			PTR_LOW_ADDR: sfr_rdata_next = ptr_reg[sel_reg][7:0];
			PTR_HIGH_ADDR: sfr_rdata_next = ptr_reg[sel_reg][15:8];
			default: sfr_rdata_next = 8'h00;
		endcase
	end

	// register all state except the falling-edge state copy on the rising edge
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			state_reg <= FIRST_STATE;
			left_reg <= 4'h1;
			idx_reg <= 4'h1;
			xmove_reg <= 1'b0;
			write_reg <= 1'b0;
			stretch_reg <= STRETCH_RST;
			mv_stretch_reg <= STRETCH_RST;
			sel_reg <= SEL_RST[SEL_BIT];
			ptr_reg[0] <= 16'h0000;
			ptr_reg[1] <= 16'h0000;
			addr_reg <= 16'h0000;
			wdata_reg <= 8'h00;
			oe_reg <= 1'b0;
			rd_n_reg <= 1'b1;
			wr_n_reg <= 1'b1;
			rd_d1_reg <= 1'b1;
			rdata_reg <= 8'h00;
			rvalid_reg <= 1'b0;
			sfr_rdata_reg <= 8'h00;
			fetch_reg <= 1'b1;
			done_reg <= 1'b0;
			xdata_s1_reg <= 8'h00;
			xdata_s2_reg <= 8'h00;
		end else begin
			state_reg <= state_next;
			left_reg <= left_next;
			idx_reg <= idx_next;
			xmove_reg <= xmove_next;
			write_reg <= write_next;
			stretch_reg <= stretch_next;
			mv_stretch_reg <= mv_stretch_next;
			sel_reg <= sel_next;
			ptr_reg <= ptr_next;
			addr_reg <= addr_next;
			wdata_reg <= wdata_next;
			oe_reg <= oe_next;
			rd_n_reg <= rd_n_next;
			wr_n_reg <= wr_n_next;
			rd_d1_reg <= rd_n_reg;
			rdata_reg <= rdata_next;
			rvalid_reg <= rvalid_next;
			sfr_rdata_reg <= sfr_rdata_next;
			fetch_reg <= (state_next == FIRST_STATE);
			done_reg <= done_next;
			xdata_s1_reg <= XDATA_I;
			xdata_s2_reg <= xdata_s1_reg;
		end
	end

	// falling-edge copy of the state marks the second half of each state
	always_ff @(negedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			late_reg <= 2'h0;
		end else begin
			late_reg <= state_reg;
		end
	end

	assign STATE_O = state_reg;
	assign STATE_LATE_O = late_reg;
	assign FETCH_O = fetch_reg;
	assign INSTR_DONE_O = done_reg;
	assign XADDR_O = addr_reg;
	assign XDATA_O = wdata_reg;
	assign XDATA_OE_O = oe_reg;
	assign XREAD_N_O = rd_n_reg;
	assign XWRITE_N_O = wr_n_reg;
	assign XMOVE_RDATA_O = rdata_reg;
	assign XMOVE_RVALID_O = rvalid_reg;
	assign SFR_RDATA_O = sfr_rdata_reg;
	assign POINTER_SELECT_O = sel_reg;
endmodule

//--- mdp_sequencer_checker.sv
// checker for the machine-cycle sequencer, bound onto its top-level ports
// assumes one core clock domain and the package reset values
module mdp_sequencer_checker
	import mdp_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK_I,
	input wire logic RST_N_I,
	// register port
	input wire logic [7:0] SFR_ADDR_I,
	input wire logic SFR_WR_I,
	input wire logic [7:0] SFR_WDATA_I,
	input wire logic [7:0] SFR_RDATA_O,
	// timing and pins
	input wire logic [1:0] STATE_O,
	input wire logic [1:0] STATE_LATE_O,
	input wire logic FETCH_O,
	input wire logic INSTR_DONE_O,
	input wire logic XDATA_OE_O,
	input wire logic XREAD_N_O,
	input wire logic XWRITE_N_O,
	input wire logic POINTER_SELECT_O
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [4:0] low_reg;
	logic [4:0] low_next;
	default clocking cb @(posedge CORE_CLK_I); endclocking
	default disable iff (!RST_N_I);
	// strobe-low clock count; 28 is the widest legal strobe so 5 bits never wrap
	always_comb begin
		low_next = (XREAD_N_O && XWRITE_N_O) ? 5'h00 : low_reg + 5'h01;
	end
	always_ff @(posedge CORE_CLK_I or negedge RST_N_I) begin
		if (!RST_N_I) begin
			low_reg <= 5'h00;
		end else begin
			low_reg <= low_next;
		end
	end
	sequence cycle_s;
		STATE_O == 2'h0 ##1 STATE_O == 2'h1 ##1 STATE_O == 2'h2 ##1 STATE_O == 2'h3;
	endsequence
	cycle_order_a: assert property (FETCH_O |-> cycle_s)
		else $error("machine cycle out of order");
	fetch_first_a: assert property (FETCH_O == (STATE_O == 2'h0))
		else $error("fetch outside first state");
	late_copy_a: assert property (STATE_LATE_O == STATE_O)
		else $error("falling-edge copy wrong");
	done_fetch_a: assert property (INSTR_DONE_O |-> FETCH_O)
		else $error("instruction end off boundary");
	write_oe_a: assert property (!XWRITE_N_O |-> XREAD_N_O && XDATA_OE_O)
		else $error("write strobe without drive");
	strobe_width_a: assert property ($rose(XREAD_N_O & XWRITE_N_O) |-> low_reg inside
		{5'h02, 5'h04, 5'h08, 5'h0c, 5'h10, 5'h14, 5'h18, 5'h1c})
		else $error("strobe width illegal");
	sel_write_a: assert property (SFR_WR_I && SFR_ADDR_I == SEL_ADDR |=>
		{7'h00, POINTER_SELECT_O} == ($past(SFR_WDATA_I) & 8'h01))
		else $error("select bit not taken from bit zero");
	sel_read_a: assert property (SFR_ADDR_I == SEL_ADDR |=>
		SFR_RDATA_O == {7'h00, $past(POINTER_SELECT_O)})
		else $error("select register read wrong");
endmodule

bind mdp_sequencer mdp_sequencer_checker mdp_sequencer_checker_i (.CORE_CLK_I, .RST_N_I,
	.SFR_ADDR_I, .SFR_WR_I, .SFR_WDATA_I, .SFR_RDATA_O, .STATE_O, .STATE_LATE_O, .FETCH_O,
	.INSTR_DONE_O, .XDATA_OE_O, .XREAD_N_O, .XWRITE_N_O, .POINTER_SELECT_O);

//--- mdp_sequencer_tb_top.sv
// testbench for the machine-cycle sequencer with the external memory model
// assumes the checker binds itself; inputs change on the falling clock edge
module mdp_sequencer_tb_top import mdp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, rst_n = 1'b0, xmv = 1'b0, xwr = 1'b0, xptr = 1'b0, pinc = 1'b0, swr = 1'b0;
	logic [2:0] cyc = 3'h1;
	logic [7:0] wreg = 8'h00, p2 = 8'h00, wd = 8'h00, sa = 8'h00, swd = 8'h00;
	logic fetch, done, xoe, rdn, wrn, rv, sel;
	logic [7:0] srd, xd, xdi, xrd;
	logic [1:0] st, stl;
	logic [15:0] xa;
	int n_mismatch = 0;
	int n_tests = 0;
	mdp_sequencer mdp_sequencer_i (.CORE_CLK_I(clk), .RST_N_I(rst_n), .INSTR_CYCLES_I(cyc),
		.INSTR_XMOVE_I(xmv), .XMOVE_WRITE_I(xwr), .XMOVE_VIA_POINTER_I(xptr), .WORK_REG_I(wreg),
		.PORT2_LATCH_I(p2), .XMOVE_WDATA_I(wd), .POINTER_INC_I(pinc), .SFR_ADDR_I(sa),
		.SFR_WR_I(swr), .SFR_WDATA_I(swd), .SFR_RDATA_O(srd), .STATE_O(st), .STATE_LATE_O(stl),
		.FETCH_O(fetch), .INSTR_DONE_O(done), .XADDR_O(xa), .XDATA_O(xd), .XDATA_OE_O(xoe),
		.XDATA_I(xdi), .XREAD_N_O(rdn), .XWRITE_N_O(wrn), .XMOVE_RDATA_O(xrd),
		.XMOVE_RVALID_O(rv), .POINTER_SELECT_O(sel));
	mdp_xmem_model mdp_xmem_model_i (.clk_i(clk), .addr_i(xa), .wdata_i(xd), .oe_i(xoe),
		.rd_n_i(rdn), .wr_n_i(wrn), .rdata_o(xdi));
	// 20 MHz core clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t ns: saw %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		sa = a;
		swd = d;
		swr = 1'b1;
		@(negedge clk);
		swr = 1'b0;
		// one idle edge, so a following write never raises the strobe in this time step
		@(negedge clk);
	endtask
	// read data lags the address by one edge
	task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
		sa = a;
		@(negedge clk);
		check({8'h00, srd}, {8'h00, exp});
	endtask
	// issue one instruction after a one-cycle filler, then time it to the next end pulse
	task automatic run_op(input logic mv, w, p, input logic [2:0] c, input int len,
		input logic [15:0] ea);
		int n;
		int lo;
		int v;
		n = 0;
		lo = 0;
		v = 0;
		cyc = c;
		xmv = mv;
		xwr = w;
		xptr = p;
		while (st !== 2'h3) @(negedge clk);
		@(negedge clk);
		cyc = 3'h1;
		xmv = 1'b0;
		if (mv) check(xa, ea);
		do begin
			@(negedge clk);
			n++;
			if (rdn !== 1'b1 || wrn !== 1'b1) lo++;
			if (rv === 1'b1) v++;
		end while (done !== 1'b1 && n < 60);
		check(16'(n), 16'(len));
		check(16'(lo), 16'(!mv ? 0 : len == 8 ? 2 : len - 8));
		check(16'(v), 16'(mv && !w));
		if (mv && w) check({8'h00, mdp_xmem_model_i.mem[ea[7:0]]}, {8'h00, wd});
		if (mv && !w) check({8'h00, xrd}, {8'h00, ea[7:0] ^ 8'h5a});
	endtask
	task automatic t_reset();
		check({15'h0000, sel}, 16'h0000);
		sfr_rd(SEL_ADDR, 8'h00);
		sfr_rd(CLKCTL_ADDR, 8'h01);
		run_op(1'b1, 1'b0, 1'b0, 3'h1, 12, 16'h0000);
	endtask
	task automatic t_select();
		sfr_wr(SEL_ADDR, 8'hff);
		sfr_rd(SEL_ADDR, 8'h01);
		sfr_wr(SEL_ADDR, 8'h02);
		check({15'h0000, sel}, 16'h0000);
		sfr_wr(8'h87, 8'h01);
		sfr_rd(8'h87, 8'h00);
	endtask
	task automatic t_pointers();
		sfr_wr(PTR_LOW_ADDR, 8'h34);
		sfr_wr(PTR_HIGH_ADDR, 8'h12);
		sfr_wr(SEL_ADDR, 8'h01);
		sfr_wr(PTR_LOW_ADDR, 8'hff);
		sfr_wr(PTR_HIGH_ADDR, 8'h56);
		pinc = 1'b1;
		@(negedge clk);
		pinc = 1'b0;
		sfr_rd(PTR_HIGH_ADDR, 8'h57);
		run_op(1'b1, 1'b0, 1'b1, 3'h1, 12, 16'h5700);
		sfr_wr(SEL_ADDR, 8'h00);
		wd = 8'ha5;
		run_op(1'b1, 1'b1, 1'b1, 3'h1, 12, 16'h1234);
	endtask
	task automatic t_lengths();
		for (int c = 0; c < 8; c++)
			run_op(1'b0, 1'b0, 1'b0, 3'(c), 4 * (c == 0 ? 1 : c > 5 ? 5 : c), 16'h0000);
	endtask
	task automatic t_stretch();
		for (int s = 0; s < 8; s++) begin
			sfr_wr(CLKCTL_ADDR, 8'(s) | 8'hf8);
			sfr_rd(CLKCTL_ADDR, 8'(s));
			wreg = 8'(s * 17);
			p2 = 8'(8'hc0 + s);
			wd = 8'(s) ^ 8'h3c;
			run_op(1'b1, s[0], 1'b0, 3'h1, (2 + s) * 4, {p2, wreg});
		end
	endtask
	// main sequence: reset held for 20 clocks, then each scenario in turn
	initial begin
		repeat (20) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_select();
		t_pointers();
		t_lengths();
		t_stretch();
		tally_and_finish();
	end
	// watchdog: the whole run needs well under a thousand clocks
	initial begin
		repeat (4000) @(posedge clk);
		n_mismatch++;
		tally_and_finish();
	end
endmodule

//--- mdp_strobe_if.sv
// carrier between the sequencer and its strobe timer
// assumes both ends sit on the core clock
interface mdp_strobe_if;
	logic start;
	logic [4:0] width;
	logic active;
	modport ctrl (output start, output width, input active);
	modport timer (input start, input width, output active);
endinterface

//--- mdp_strobe_timer.sv
// strobe timer: holds active for exactly 'width' clocks after a start pulse
// assumes the start pulse only comes while idle
module mdp_strobe_timer
	import mdp_pkg::*;
(
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// link to the sequencer
	mdp_strobe_if.timer strb
);
	logic [4:0] left_reg;
	logic [4:0] left_next;
	logic active_reg;
	logic active_next;

	// load on start, then count down; active while clocks remain
	always_comb begin
		left_next = left_reg;
		active_next = 1'b0;
		if (strb.start) begin
			left_next = strb.width - 5'h01;
			active_next = 1'b1;
		end else if (left_reg != 5'h00) begin
			left_next = left_reg - 5'h01;
			active_next = 1'b1;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			left_reg <= 5'h00;
			active_reg <= 1'b0;
		end else begin
			left_reg <= left_next;
			active_reg <= active_next;
		end
	end

	assign strb.active = active_reg;
endmodule

//--- mdp_xmem_model.sv
// external data memory model on the far side of the move pins
// assumes active-low strobes; only the low address byte selects a cell
module mdp_xmem_model (
	// clock
	input wire logic clk_i,
	// move pins
	input wire logic [15:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic oe_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	output logic [7:0] rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] mem [0:255];
	logic [7:0] last = 8'h00;
	// distinct preset bytes so a wrong address shows up
	initial begin
		for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
	end
	// released pins toggle each clock, so a sample outside the strobe cannot match
	always @(posedge clk_i) last <= rdata_o;
	assign rdata_o = rd_n_i ? ~last : mem[addr_i[7:0]];
	// write lands on the closing strobe edge while data is still driven
	always @(posedge wr_n_i)
		if (oe_i) mem[addr_i[7:0]] <= wdata_i;
endmodule
